// *** verilog/crs_pkg.sv ***
// Operation
// - Converts streams among 4:4:4, 4:2:2 and 4:2:0, formats set by configuration.
// - 4:2:2 keeps plane one full; planes two and three carry half the columns.
// - 4:2:0 halves planes two and three both across and down.
// - All modes take chroma as co-sited with the luma of odd columns.
// - Horizontal conversion nearest or filtered; vertical conversion nearest only.
// - New frame width and height are taken from control packets at run time.
// - Horizontal chroma scaling is a fixed factor of two up or down.
// - Nearest downsampling drops chroma of even columns, first column numbered one.
// - Filtered downsampling applies a fixed nine-tap lowpass before decimation.
// - Downsampling weights are sums of powers of two built from shifts and adds.
// - Nearest upsampling repeats each chroma pair into the following column.
// - Filtered upsampling: phase zero on odd columns, phase one-half on even.
// - Phase zero is a pass-through; half phase uses shift-add fixed weights.
// - Luma-adaptive mode finds luma edges and shifts chroma phase away from them.
// - Adaptive phase 0 moves to -1/4, 0, 1/4; phase 1/2 to 1/4, 1/2, 3/4.
// - Adaptive logic uses no memory or multiplier, only extra logic.
// - Chroma order is Cb on odd columns then Cr, luma on every beat.
// - Samples are unsigned N-bit values from zero to two to the N minus one.
package crs_pkg;

    typedef enum logic [1:0] {FMT_444, FMT_422, FMT_420} crs_fmt_t;

    typedef enum logic [2:0] {
        OP_CENTER,
        OP_PREV,
        OP_DOWN9,
        OP_HALF,
        OP_EVEN_Q1,
        OP_EVEN_Q3,
        OP_ODD_M,
        OP_ODD_P
    } crs_op_t;

    localparam int TAPS         = 9;
    localparam int MID          = 4;
    localparam int FLUSH_BEATS  = 4;
    localparam int FIRST_COL    = 1;
    localparam int DIM_W        = 16;
    localparam int NIB_W        = 4;
    localparam int CTRL_NIBBLES = 8;
    localparam int SHADOW_W     = CTRL_NIBBLES * NIB_W;
    localparam int CNT_W        = 4;
    localparam int FLUSH_W      = 3;

    localparam logic [3:0] PKT_VIDEO   = 4'h0;
    localparam logic [3:0] PKT_CONTROL = 4'hF;

    // Decimator weights -2 0 8 16 20 16 8 0 -2 over 64
    localparam int DOWN_SHIFT = 6;
    // Half-phase weights -1 9 9 -1 over 16
    localparam int HALF_SHIFT = 4;
    // Quarter-phase weights 3 1 over 4
    localparam int Q_SHIFT    = 2;

endpackage : crs_pkg

// *** verilog/crs_chroma_filter.sv ***
`timescale 1ns/100ps
module crs_chroma_filter #(
    parameter int BITS = 8
) (
    // Window of one chroma plane, tap k at column offset k-MID
    input  logic [crs_pkg::TAPS*BITS-1:0] taps,
    input  crs_pkg::crs_op_t              op,
    // Filtered sample
    output logic [BITS-1:0]               sample
);
    localparam int ACC_W = BITS + 8;
    localparam int M     = crs_pkg::MID;
    localparam logic signed [ACC_W-1:0] DOWN_RND = ACC_W'(1 << (crs_pkg::DOWN_SHIFT - 1));
    localparam logic signed [ACC_W-1:0] HALF_RND = ACC_W'(1 << (crs_pkg::HALF_SHIFT - 1));
    localparam logic signed [ACC_W-1:0] Q_RND    = ACC_W'(1 << (crs_pkg::Q_SHIFT - 1));

    logic signed [ACC_W-1:0] t [crs_pkg::TAPS];
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] maxVal;
    logic signed [ACC_W-1:0] pairIn;
    logic signed [ACC_W-1:0] pairHalf;

    genvar k;
    generate
        for (k = 0; k < crs_pkg::TAPS; k++) begin : g_unpack
            assign t[k] = {{(ACC_W-BITS){1'b0}}, taps[k*BITS +: BITS]};
        end
    endgenerate

    assign maxVal   = {{(ACC_W-BITS){1'b0}}, {BITS{1'b1}}};
    assign pairIn   = t[M-1] + t[M+1];
    assign pairHalf = t[M-2] + t[M+2];

    // Shift-add only; no multiplier or memory
    always_comb begin
        unique case (op)
            crs_pkg::OP_CENTER:  acc = t[M];
            crs_pkg::OP_PREV:    acc = t[M-1];
            crs_pkg::OP_DOWN9:   acc = ((t[M] <<< 4) + (t[M] <<< 2) + (pairIn <<< 4)
                                       + (pairHalf <<< 3) - ((t[0] + t[M+M]) <<< 1)
                                       + DOWN_RND) >>> crs_pkg::DOWN_SHIFT;
            crs_pkg::OP_HALF:    acc = ((pairIn <<< 3) + pairIn - t[M-3] - t[M+3]
                                       + HALF_RND) >>> crs_pkg::HALF_SHIFT;
            crs_pkg::OP_EVEN_Q1: acc = ((t[M-1] <<< 1) + t[M-1] + t[M+1] + Q_RND)
                                       >>> crs_pkg::Q_SHIFT;
            crs_pkg::OP_EVEN_Q3: acc = ((t[M+1] <<< 1) + t[M+1] + t[M-1] + Q_RND)
                                       >>> crs_pkg::Q_SHIFT;
            crs_pkg::OP_ODD_M:   acc = ((t[M] <<< 1) + t[M] + t[M-2] + Q_RND)
                                       >>> crs_pkg::Q_SHIFT;
            crs_pkg::OP_ODD_P:   acc = ((t[M] <<< 1) + t[M] + t[M+2] + Q_RND)
                                       >>> crs_pkg::Q_SHIFT;
        endcase
    end

    // Clamp to the unsigned sample range
    always_comb begin
        if (acc < 0) begin
            sample = '0;
        end else if (acc > maxVal) begin
            sample = {BITS{1'b1}};
        end else begin
            sample = acc[BITS-1:0];
        end
    end

endmodule : crs_chroma_filter

// *** verilog/crs_chroma_resampler.sv ***
`timescale 1ns/100ps
module crs_chroma_resampler #(
    parameter int BITS       = 8,
    parameter int MAX_WIDTH  = 1920,
    parameter int MAX_HEIGHT = 1080,
    parameter int EDGE_THR   = 16
) (
    // Clock and reset
    input  logic                        clk,
    input  logic                        reset,
    // Configuration
    input  crs_pkg::crs_fmt_t           inFormat,
    input  crs_pkg::crs_fmt_t           outFormat,
    input  logic                        filterEnable,
    input  logic                        lumaAdaptive,
    // Frame size status
    output logic [crs_pkg::DIM_W-1:0]   frameWidth,
    output logic [crs_pkg::DIM_W-1:0]   frameHeight,
    // Input stream
    input  logic                        inValid,
    output logic                        inReady,
    input  logic                        inSop,
    input  logic                        inEop,
    input  logic [BITS-1:0]             inY,
    input  logic [BITS-1:0]             inCb,
    input  logic [BITS-1:0]             inCr,
    // Output stream
    output logic                        outValid,
    input  logic                        outReady,
    output logic                        outSop,
    output logic                        outEop,
    output logic [BITS-1:0]             outY,
    output logic [BITS-1:0]             outCb,
    output logic [BITS-1:0]             outCr
);
    localparam int TAPS  = crs_pkg::TAPS;
    localparam int MID   = crs_pkg::MID;
    localparam int DW    = crs_pkg::DIM_W;
    localparam int BUF_W = $clog2(MAX_WIDTH);

    // Input side state
    logic                               inTake;
    logic                               isVideo;
    logic                               isCtrl;
    logic                               newPix;
    logic                               lineEnd;
    logic [DW-1:0]                      col;
    logic [DW-1:0]                      row;
    logic [BITS-1:0]                    cIn;
    logic [BITS-1:0]                    lineBuf [MAX_WIDTH];
    logic [BUF_W-1:0]                   bufIdx;
    logic                               vUp;
    logic                               vDown;
    logic                               hUp;
    logic                               hDown;

    // Control packet parsing
    logic [crs_pkg::SHADOW_W-1:0]       ctrlShadow;
    logic [crs_pkg::SHADOW_W-1:0]       next_ctrlShadow;
    logic [crs_pkg::CNT_W-1:0]          ctrlCnt;
    logic [crs_pkg::CNT_W-1:0]          next_ctrlCnt;

    // Window: index 0 newest, MID is the column being produced
    logic [BITS-1:0]                    wY   [TAPS];
    logic [BITS-1:0]                    wA   [TAPS];
    logic [BITS-1:0]                    wB   [TAPS];
    logic [DW-1:0]                      wCol [TAPS];
    logic [TAPS-1:0]                    wVal;
    logic [TAPS-1:0]                    wPix;
    logic [TAPS-1:0]                    wSop;
    logic [TAPS-1:0]                    wEop;
    logic [TAPS-1:0]                    wOdd;

    // Flow control
    logic                               centerFresh;
    logic                               next_centerFresh;
    logic [crs_pkg::FLUSH_W-1:0]        flushCnt;
    logic [crs_pkg::FLUSH_W-1:0]        next_flushCnt;
    logic                               flushShift;
    logic                               shiftNow;
    logic                               take;

    // Filtering
    logic [TAPS*BITS-1:0]               cbTaps;
    logic [TAPS*BITS-1:0]               crTaps;
    logic [BITS-1:0]                    cbOut;
    logic [BITS-1:0]                    crOut;
    logic [BITS-1:0]                    crHold;
    logic [BITS-1:0]                    yL;
    logic [BITS-1:0]                    yR;
    crs_pkg::crs_op_t                   op;
    int                                 center;
    int                                 width;
    int                                 dl;
    int                                 dr;
    logic                               colOdd;

    // Nearest column of the same plane inside the line, as a window index
    function automatic int tapIdx(input int off, input logic keepPar,
                                  input int n, input int wid);
        int c;
        int idx;
        c = n + off;
        if (c < crs_pkg::FIRST_COL) begin
            c = (keepPar && !c[0]) ? crs_pkg::FIRST_COL + 1 : crs_pkg::FIRST_COL;
        end else if (c > wid) begin
            c = (keepPar && (c[0] != wid[0])) ? wid - 1 : wid;
        end
        idx = MID - (c - n);
        if (idx < 0) begin
            idx = 0;
        end else if (idx > TAPS - 1) begin
            idx = TAPS - 1;
        end
        return idx;
    endfunction : tapIdx

    // Path selection
    assign hUp   = (inFormat != crs_pkg::FMT_444) && (outFormat == crs_pkg::FMT_444);
    assign hDown = (inFormat == crs_pkg::FMT_444) && (outFormat != crs_pkg::FMT_444);
    assign vUp   = (inFormat == crs_pkg::FMT_420) && (outFormat != crs_pkg::FMT_420);
    assign vDown = (inFormat != crs_pkg::FMT_420) && (outFormat == crs_pkg::FMT_420);

    assign inTake  = inValid && inReady;
    assign newPix  = inTake && !inSop && isVideo;
    assign lineEnd = (col >= frameWidth);
    assign bufIdx  = BUF_W'(col - DW'(crs_pkg::FIRST_COL));

    // Vertical nearest: even rows reuse the chroma of the row above
    assign cIn = (vUp && !row[0]) ? lineBuf[bufIdx] : inCb;

    always_ff @(posedge clk) begin
        if (newPix && vUp && row[0] && col <= DW'(MAX_WIDTH)) begin
            lineBuf[bufIdx] <= inCb;
        end
    end

    // Packet kind and pixel position
    always_ff @(posedge clk) begin
        if (reset) begin
            isVideo <= 1'b0;
            isCtrl  <= 1'b0;
            col     <= DW'(crs_pkg::FIRST_COL);
            row     <= DW'(crs_pkg::FIRST_COL);
        end else if (inTake && inSop) begin
            isVideo <= inY[crs_pkg::NIB_W-1:0] == crs_pkg::PKT_VIDEO;
            isCtrl  <= inY[crs_pkg::NIB_W-1:0] == crs_pkg::PKT_CONTROL;
            col     <= DW'(crs_pkg::FIRST_COL);
            row     <= DW'(crs_pkg::FIRST_COL);
        end else if (newPix) begin
            if (lineEnd) begin
                col <= DW'(crs_pkg::FIRST_COL);
                row <= row + 1'b1;
            end else begin
                col <= col + 1'b1;
            end
        end
    end

    // Width and height nibbles, most significant first
    always_comb begin
        next_ctrlShadow = ctrlShadow;
        next_ctrlCnt    = ctrlCnt;
        if (ctrlCnt < crs_pkg::CNT_W'(crs_pkg::CTRL_NIBBLES)) begin
            next_ctrlShadow = {ctrlShadow[crs_pkg::SHADOW_W-crs_pkg::NIB_W-1:0],
                               inY[crs_pkg::NIB_W-1:0]};
            next_ctrlCnt    = ctrlCnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrlShadow  <= '0;
            ctrlCnt     <= '0;
            frameWidth  <= DW'(MAX_WIDTH);
            frameHeight <= DW'(MAX_HEIGHT);
        end else if (inTake && inSop) begin
            ctrlCnt <= '0;
        end else if (inTake && isCtrl) begin
            ctrlShadow <= next_ctrlShadow;
            ctrlCnt    <= next_ctrlCnt;
            if (inEop && next_ctrlCnt == crs_pkg::CNT_W'(crs_pkg::CTRL_NIBBLES)
                && next_ctrlShadow[crs_pkg::SHADOW_W-1 -: DW] != '0) begin
                frameWidth  <= next_ctrlShadow[crs_pkg::SHADOW_W-1 -: DW];
                frameHeight <= next_ctrlShadow[DW-1:0];
            end
        end
    end

    // Every beat walks the window so packets keep their order
    always_ff @(posedge clk) begin
        if (reset) begin
            wVal <= '0;
            wPix <= '0;
            wSop <= '0;
            wEop <= '0;
            wOdd <= '0;
        end else if (shiftNow) begin
            for (int i = TAPS - 1; i > 0; i--) begin
                wY[i]   <= wY[i-1];
                wA[i]   <= wA[i-1];
                wB[i]   <= wB[i-1];
                wCol[i] <= wCol[i-1];
            end
            wVal    <= {wVal[TAPS-2:0], inTake};
            wPix    <= {wPix[TAPS-2:0], newPix};
            wSop    <= {wSop[TAPS-2:0], inSop};
            wEop    <= {wEop[TAPS-2:0], inEop};
            wOdd    <= {wOdd[TAPS-2:0], row[0]};
            wY[0]   <= inY;
            wA[0]   <= cIn;
            wB[0]   <= inCr;
            wCol[0] <= col;
        end
    end

    // A line or packet end is followed by empty slots to drain the window
    assign flushShift = (flushCnt != '0) && !centerFresh;
    assign shiftNow   = inTake || flushShift;
    assign take       = centerFresh && (!outValid || outReady);

    always_comb begin
        next_flushCnt = flushCnt;
        if (inTake && (inEop || (newPix && lineEnd))) begin
            next_flushCnt = crs_pkg::FLUSH_W'(crs_pkg::FLUSH_BEATS);
        end else if (flushShift) begin
            next_flushCnt = flushCnt - 1'b1;
        end
        if (shiftNow) begin
            next_centerFresh = wVal[MID-1];
        end else begin
            next_centerFresh = centerFresh && !take;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            flushCnt    <= '0;
            centerFresh <= 1'b0;
            inReady     <= 1'b0;
        end else begin
            flushCnt    <= next_flushCnt;
            centerFresh <= next_centerFresh;
            inReady     <= (next_flushCnt == '0) && !next_centerFresh;
        end
    end

    // Tap gathering with edge reuse
    assign center = int'(wCol[MID]);
    assign width  = int'(frameWidth);
    assign colOdd = wCol[MID][0];

    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_taps
            assign cbTaps[k*BITS +: BITS] =
                wA[tapIdx(k - MID, hUp, center, width)];
            assign crTaps[k*BITS +: BITS] = hUp ?
                wA[tapIdx(k - MID + 1, 1'b1, center, width)] :
                wB[tapIdx(k - MID, 1'b0, center, width)];
        end
    endgenerate

    assign yL = wY[tapIdx(-1, 1'b0, center, width)];
    assign yR = wY[tapIdx(1, 1'b0, center, width)];

    // Luma steps on each side of the column
    always_comb begin
        dl = int'(wY[MID]) - int'(yL);
        dr = int'(yR) - int'(wY[MID]);
        if (dl < 0) begin
            dl = -dl;
        end
        if (dr < 0) begin
            dr = -dr;
        end
    end

    always_comb begin
        op = crs_pkg::OP_CENTER;
        if (hDown && filterEnable) begin
            op = crs_pkg::OP_DOWN9;
        end else if (hUp) begin
            if (!colOdd) begin
                op = filterEnable ? crs_pkg::OP_HALF : crs_pkg::OP_PREV;
            end
            if (filterEnable && lumaAdaptive) begin
                if (dl > dr + EDGE_THR) begin
                    op = colOdd ? crs_pkg::OP_ODD_P : crs_pkg::OP_EVEN_Q3;
                end else if (dr > dl + EDGE_THR) begin
                    op = colOdd ? crs_pkg::OP_ODD_M : crs_pkg::OP_EVEN_Q1;
                end
            end
        end
    end

    crs_chroma_filter #(
        .BITS   (BITS)
    ) u_cb_filter (
        .taps   (cbTaps),
        .op     (op),
        .sample (cbOut)
    );

    crs_chroma_filter #(
        .BITS   (BITS)
    ) u_cr_filter (
        .taps   (crTaps),
        .op     (op),
        .sample (crOut)
    );

    // Cr of an odd column waits one column for its 4:2:2 slot
    always_ff @(posedge clk) begin
        if (reset) begin
            crHold <= '0;
        end else if (take && wPix[MID] && hDown && colOdd) begin
            crHold <= crOut;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            outValid <= 1'b0;
            outSop   <= 1'b0;
            outEop   <= 1'b0;
            outY     <= '0;
            outCb    <= '0;
            outCr    <= '0;
        end else if (take) begin
            outValid <= 1'b1;
            outSop   <= wSop[MID];
            outEop   <= wEop[MID];
            outY     <= wY[MID];
            outCb    <= wA[MID];
            outCr    <= wB[MID];
            if (wPix[MID]) begin
                if (hUp) begin
                    outCb <= cbOut;
                    outCr <= crOut;
                end else if (outFormat != crs_pkg::FMT_444) begin
                    outCr <= '0;
                    if (hDown) begin
                        outCb <= colOdd ? cbOut : crHold;
                    end
                    if (vDown && !wOdd[MID]) begin
                        outCb <= '0;
                    end
                end
            end
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end

endmodule : crs_chroma_resampler

// *** tb/crs_sink_model.sv ***
`timescale 1ns/100ps
module crs_sink_model (
    // Clock and reset
    input  logic clk,
    input  logic reset,
    // Pace select
    input  logic slow,
    // Downstream handshake
    output logic outReady
);
    logic [1:0] phase;
    always_ff @(posedge clk) begin
        if (reset) begin
            phase <= 2'h0;
        end else begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        end
    end
    // Slow pace takes one beat in three and accepts any lane value
    assign outReady = slow ? (phase == 2'h2) : 1'b1;
endmodule : crs_sink_model

// *** tb/crs_chroma_resampler_properties.sv ***
`timescale 1ns/100ps
module crs_chroma_resampler_properties #(
    parameter int BITS      = 8,
    parameter int MAX_WIDTH = 1920
) (
    // Clock, reset, configuration
    input logic                      clk, reset, filterEnable,
    input crs_pkg::crs_fmt_t         inFormat, outFormat,
    input logic [crs_pkg::DIM_W-1:0] frameWidth,
    // Streams
    input logic                      inValid, inReady, inEop, outValid, outReady, outSop, outEop,
    input logic [BITS-1:0]           outY, outCb, outCr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic                      video;
    logic [crs_pkg::DIM_W-1:0] col;
    logic [BITS-1:0]           prevCb, prevCr;
    wire take = outValid && outReady;
    wire pix  = outValid && video && !outSop;
    wire even = (col != frameWidth) && col[0];
    // Column of the last pixel beat taken, first column numbered one
    always_ff @(posedge clk) begin
        if (reset) begin
            video <= 1'b0;
            col <= '0;
        end else if (take && outSop) begin
            video <= (outY[3:0] == 4'h0);
            col <= '0;
        end else if (take && video) begin
            col <= (col == frameWidth) ? 16'h0001 : col + 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (take) begin
            prevCb <= outCb;
            prevCr <= outCr;
        end
    end
    property p_reset_idle;
        $fell(reset) |-> !inReady && !outValid && frameWidth == MAX_WIDTH;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
    property p_hold;
        outValid && !outReady |=> outValid && $stable({outSop, outEop, outY, outCb, outCr});
    endproperty
    a_hold: assert property (p_hold) else $error("beat changed before taken");
    property p_ready_gap;
        $rose(outValid) |-> !$past(inReady);
    endproperty
    a_ready_gap: assert property (p_ready_gap) else $error("beat left while input open");
    property p_eop_flush;
        inValid && inReady && inEop |=> !inReady [*2];
    endproperty
    a_eop_flush: assert property (p_eop_flush) else $error("no flush after eop");
    property p_cr_zero;
        pix && outFormat != crs_pkg::FMT_444 |-> outCr == '0;
    endproperty
    a_cr_zero: assert property (p_cr_zero) else $error("Cr lane set in 4:2:2");
    property p_width_nonzero;
        frameWidth != 16'h0000;
    endproperty
    a_width_nonzero: assert property (p_width_nonzero) else $error("zero width");
    property p_near_up;
        pix && even && !filterEnable && inFormat == crs_pkg::FMT_422
            && outFormat == crs_pkg::FMT_444 |-> outCb == prevCb && outCr == prevCr;
    endproperty
    a_near_up: assert property (p_near_up) else $error("pair not repeated");
    property p_fell_after_take;
        $fell(outValid) |-> $past(outReady);
    endproperty
    a_fell_after_take: assert property (p_fell_after_take) else $error("beat dropped");
    c_eop: cover property (take && outEop);
    c_stall: cover property (outValid && !outReady);
    c_resize: cover property ($changed(frameWidth));
endmodule : crs_chroma_resampler_properties

// *** tb/crs_chroma_resampler_tb_top.sv ***
`timescale 1ns/100ps
module crs_chroma_resampler_tb_top;
    logic              clk, reset, filterEnable, lumaAdaptive, inValid, inSop, inEop, slow;
    logic              inReady, outValid, outReady, outSop, outEop;
    crs_pkg::crs_fmt_t inFormat, outFormat;
    logic [15:0]       frameWidth, frameHeight;
    logic [7:0]        inY, inCb, inCr, outY, outCb, outCr;
    logic [7:0]        pY[4], pCb[4], pCr[4], eCb[4], eCr[4], gY[16], gCb[16], gCr[16];
    int                outN, err_total, samples_checked, cycles;
    crs_chroma_resampler #(.BITS(8), .MAX_WIDTH(16), .MAX_HEIGHT(8), .EDGE_THR(16)) uut (
        .clk(clk), .reset(reset), .inFormat(inFormat), .outFormat(outFormat),
        .filterEnable(filterEnable), .lumaAdaptive(lumaAdaptive),
        .frameWidth(frameWidth), .frameHeight(frameHeight), .inValid(inValid),
        .inReady(inReady), .inSop(inSop), .inEop(inEop), .inY(inY), .inCb(inCb),
        .inCr(inCr), .outValid(outValid), .outReady(outReady), .outSop(outSop),
        .outEop(outEop), .outY(outY), .outCb(outCb), .outCr(outCr));
    crs_sink_model sink (.clk(clk), .reset(reset), .slow(slow), .outReady(outReady));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            stop_test();
        end
        if (reset === 1'b0 && outValid === 1'b1 && outReady === 1'b1 && outN < 16) begin
            gY[outN] = outY;
            gCb[outN] = outCb;
            gCr[outN] = outCr;
            outN++;
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16
    // Holds the beat until an edge samples inReady high
    task automatic sendBeat(input logic s, input logic e, input logic [7:0] y, cb, cr);
        int n = 0;
        {inValid, inSop, inEop, inY, inCb, inCr} = {1'b1, s, e, y, cb, cr};
        do begin
            @(posedge clk);
            n++;
        end while (inReady !== 1'b1 && n < 100);
        if (inReady !== 1'b1) err_total++;
        #1;
    endtask : sendBeat
    task automatic waitOut(input int n);
        for (int k = 0; k < 500 && outN < n; k++) @(posedge clk);
        if (outN < n) err_total++;
        #1;
    endtask : waitOut
    // Video header then one line of four pixels on parallel lanes
    task automatic sendFrame(input crs_pkg::crs_fmt_t fi, fo, input logic f);
        inFormat = fi;
        outFormat = fo;
        filterEnable = f;
        outN = 0;
        sendBeat(1'b1, 1'b0, 8'h00, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) sendBeat(1'b0, i == 3, pY[i], pCb[i], pCr[i]);
        inValid = 1'b0;
        waitOut(5);
        chk8(gY[0], 8'h00);
        for (int i = 0; i < 4; i++) begin
            chk8(gY[i + 1], pY[i]);
            chk8(gCb[i + 1], eCb[i]);
            chk8(gCr[i + 1], eCr[i]);
        end
    endtask : sendFrame
    task automatic testControl();
        logic [31:0] d = 32'h0004_0001;
        outN = 0;
        sendBeat(1'b1, 1'b0, 8'h0F, 8'h00, 8'h00);
        for (int i = 0; i < 8; i++) sendBeat(1'b0, i == 7, {4'h0, d[31-4*i -: 4]}, 8'h00, 8'h00);
        inValid = 1'b0;
        waitOut(9);
        chk16(frameWidth, 16'h0004);
        chk16(frameHeight, 16'h0001);
        chk8(gY[0], 8'h0F);
    endtask : testControl
    task automatic testNearDown();
        pY = '{8'h30, 8'h31, 8'h32, 8'h33};
        pCb = '{8'h10, 8'h11, 8'h12, 8'h13};
        pCr = '{8'h20, 8'h21, 8'h22, 8'h23};
        eCb = '{8'h10, 8'h20, 8'h12, 8'h22};
        eCr = '{4{8'h00}};
        sendFrame(crs_pkg::FMT_444, crs_pkg::FMT_422, 1'b0);
    endtask : testNearDown
    task automatic testNearUp();
        slow = 1'b1;
        pCb = '{8'h21, 8'h52, 8'h33, 8'h74};
        pCr = '{4{8'h00}};
        eCb = '{8'h21, 8'h21, 8'h33, 8'h33};
        eCr = '{8'h52, 8'h52, 8'h74, 8'h74};
        sendFrame(crs_pkg::FMT_422, crs_pkg::FMT_444, 1'b0);
        slow = 1'b0;
    endtask : testNearUp
    task automatic testFiltUp();
        pY = '{4{8'h80}};
        pCb = '{8'h20, 8'h40, 8'h30, 8'h60};
        eCb = '{8'h20, 8'h28, 8'h30, 8'h31};
        eCr = '{8'h40, 8'h50, 8'h60, 8'h62};
        sendFrame(crs_pkg::FMT_422, crs_pkg::FMT_444, 1'b1);
    endtask : testFiltUp
    // Luma step between columns 3 and 4 moves both phases
    task automatic testAdapt();
        lumaAdaptive = 1'b1;
        pY = '{8'h10, 8'h10, 8'h10, 8'h90};
        eCb = '{8'h20, 8'h28, 8'h2C, 8'h30};
        eCr = '{8'h40, 8'h50, 8'h58, 8'h60};
        sendFrame(crs_pkg::FMT_422, crs_pkg::FMT_444, 1'b1);
        lumaAdaptive = 1'b0;
    endtask : testAdapt
    task automatic testFiltDown();
        pCb = '{4{8'h64}};
        pCr = '{4{8'h64}};
        eCb = '{4{8'h64}};
        eCr = '{4{8'h00}};
        sendFrame(crs_pkg::FMT_444, crs_pkg::FMT_420, 1'b1);
    endtask : testFiltDown
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    initial begin
        {inValid, inSop, inEop, inY, inCb, inCr, filterEnable, lumaAdaptive, slow} = '0;
        inFormat = crs_pkg::FMT_444;
        outFormat = crs_pkg::FMT_444;
        {reset, outN, err_total, samples_checked, cycles} = {1'b1, 128'h0};
        repeat (5) @(posedge clk);
        #1;
        chk16(frameWidth, 16'h0010);
        reset = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        testControl();
        testNearDown();
        testNearUp();
        testFiltUp();
        testAdapt();
        testFiltDown();
        stop_test();
    end
endmodule : crs_chroma_resampler_tb_top
bind crs_chroma_resampler crs_chroma_resampler_properties #(
    .BITS(BITS), .MAX_WIDTH(MAX_WIDTH)) chk (
    .clk(clk), .reset(reset), .filterEnable(filterEnable), .inFormat(inFormat),
    .outFormat(outFormat), .frameWidth(frameWidth), .inValid(inValid), .inReady(inReady),
    .inEop(inEop), .outValid(outValid), .outReady(outReady), .outSop(outSop),
    .outEop(outEop), .outY(outY), .outCb(outCb), .outCr(outCr));
